// ---- rtl/smsr_pkg.sv ----
// Shared constants, states and carriers of the supply monitor status register bank
package smsr_pkg;

  // Command codes of the register bank
  localparam logic [7:0] CMD_VIN_OV_WARN   = 8'h57;
  localparam logic [7:0] CMD_VIN_UV_WARN   = 8'h58;
  localparam logic [7:0] CMD_VIN_UV_FAULT  = 8'h59;
  localparam logic [7:0] CMD_VIN_UV_ACTION = 8'h5A;
  localparam logic [7:0] CMD_OUT_GOOD      = 8'h5E;
  localparam logic [7:0] CMD_ON_DELAY      = 8'h60;
  localparam logic [7:0] CMD_ON_RAMP       = 8'h61;
  localparam logic [7:0] CMD_OFF_DELAY     = 8'h64;
  localparam logic [7:0] CMD_OFF_RAMP      = 8'h65;
  localparam logic [7:0] CMD_SUM_BYTE      = 8'h78;
  localparam logic [7:0] CMD_SUM_WORD      = 8'h79;

  // Reset values
  localparam logic [15:0] RST_VIN_OV_WARN   = 16'hD34D;
  localparam logic [7:0]  RST_VIN_UV_ACTION = 8'h80;
  localparam logic [15:0] RST_SEQ_TIME      = 16'hCA80;
  localparam logic [15:0] RST_SUMMARY       = 16'h0000;

  // Undervoltage fault action fields
  localparam int          RETRY_MODE_HI = 5;
  localparam int          RETRY_MODE_LO = 3;
  localparam int          RETRY_DLY_HI  = 2;
  localparam int          RETRY_DLY_LO  = 0;
  localparam logic [2:0]  RETRY_CONT    = 3'b111;

  // Summary word bit positions
  localparam int SB_BUSY = 7;
  localparam int SB_OFF  = 6;
  localparam int SB_VOOV = 5;
  localparam int SB_IOOC = 4;
  localparam int SB_VIUV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_CML  = 1;
  localparam int SB_NOTA = 0;
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_INP  = 13;
  localparam int SW_MFR  = 12;
  localparam int SW_PGN  = 11;
  localparam int SW_FANS = 10;
  localparam int SW_OTH  = 9;
  localparam int SW_UNK  = 8;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_MS     = 1000000;
  localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int RETRY_STEP_MS = 35;
  localparam logic [1:0] STRAP_LOAD_CYC = 2'h3;

  // Linear-11 layout and scaling of strap defaults
  localparam int          L11_EXP_HI   = 15;
  localparam int          L11_EXP_LO   = 11;
  localparam int          L11_MAN_HI   = 10;
  localparam int          L11_FRAC     = 16;
  localparam logic [14:0] L11_MAN_MAX  = 15'h03FF;
  localparam logic [14:0] UV_WARN_NUM  = 15'h000B;
  localparam logic [19:0] PG_NUM       = 20'h0_0009;
  localparam logic [19:0] SCALE_DEN    = 20'h0_000A;

  // Output sequencer states
  typedef enum logic [2:0] {
    SMSR_OFF       = 3'b000,
    SMSR_ON_DELAY  = 3'b001,
    SMSR_RISE      = 3'b010,
    SMSR_ON        = 3'b011,
    SMSR_OFF_DELAY = 3'b100,
    SMSR_FALL      = 3'b101,
    SMSR_RETRY     = 3'b110
  } smsr_state_t;

  // Detector flags from the rest of the module
  typedef struct packed {
    logic out_ov_fault;
    logic out_oc_fault;
    logic vout_warn;
    logic iout_warn;
    logic temp_alert;
    logic temp_fault;
    logic comm_fault;
    logic busy_fault;
    logic mfr_alert;
    logic fan_alert;
    logic other_alert;
    logic unknown_alert;
  } smsr_faults_t;

endpackage

// ---- rtl/smsr_regs.sv ----
// Supply monitor command registers, output sequencer and fault summary
// Operation
// - VIN above OV warn sets input flags, alert
// - VIN below UV warn sets input flags, alert
// - UV fault holds until VIN exceeds warn
// - Retry code 000 keeps output off
// - Continuous retry restarts until off or fault
// - Retry spacing is (delay+1) times 35ms
// - Power good on above threshold, off below UV
// - Wait turn-on delay before ramp up
// - Ramp up over programmed rise time
// - Wait turn-off delay before ramp down
// - Ramp down over programmed fall time
// - Sequencing times reset to 5ms code
// - Bit 7 flags busy fault
// - Bit 6 set while output unpowered
// - Bits 5 to 1 map listed faults
// - Bit 0 flags unlisted fault or warning
// - Word low byte is the byte register
// - Word high bits map fault classes
// - Bit 11 set while power good negated
// - Bit 8 flags unknown fault type
// - Summaries read-only, zero after reset
// - UV warn and good threshold from straps
`timescale 1ns/1ps
`default_nettype none
module smsr_regs
  import smsr_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                RESET,
  // Command port from the serial protocol engine
  input  wire logic [7:0]          CMD_CODE,
  input  wire logic                CMD_WR,
  input  wire logic [15:0]         CMD_WDATA,
  input  wire logic                CMD_RD,
  output logic      [15:0]         RD_DATA,
  output logic                     RD_VALID,
  output logic                     CMD_ERR,
  input  wire logic                CLEAR_FAULTS,
  // Measurements and limits
  input  wire logic [15:0]         VIN_MEAS,
  input  wire logic [15:0]         VOUT_MEAS,
  input  wire logic [15:0]         VOUT_UV_LIMIT,
  input  wire smsr_pkg::smsr_faults_t FAULTS,
  // Pins
  input  wire logic                ENABLE_PIN,
  input  wire logic [15:0]         STRAP_UV_FAULT,
  input  wire logic [15:0]         STRAP_VOUT,
  // Output stage control and indications
  output logic                     OUTPUT_ON,
  output logic                     RAMP_UP,
  output logic                     RAMP_DOWN,
  output logic                     POWER_GOOD,
  output logic                     ALERT_O,
  output logic                     ALERT_OE
);
  import smsr_pkg::*;

  // Linear-11 to fixed point with 16 fraction bits; negative mantissa clamps to zero
  function automatic logic [47:0] l11_fix(input logic [15:0] v);
    logic [5:0]  sh;
    logic [47:0] m;
    sh = 6'(signed'(v[L11_EXP_HI:L11_EXP_LO])) + 6'(L11_FRAC);
    m  = v[L11_MAN_HI] ? 48'h0000_0000_0000 : {37'h0, v[L11_MAN_HI:0]};
    return m << sh;
  endfunction

  // Whole milliseconds of a Linear-11 time, saturated
  function automatic logic [15:0] l11_ms(input logic [15:0] v);
    logic [47:0] f;
    f = l11_fix(v);
    return (|f[47:32]) ? 16'hFFFF : f[31:16];
  endfunction

  // Registers written by software
  logic [15:0] vin_ov_warn_reg;      // Input overvoltage warning threshold
  logic [15:0] vin_uv_warn_reg;      // Input undervoltage warning threshold
  logic [15:0] vin_uv_fault_reg;     // Input undervoltage fault threshold
  logic [7:0]  vin_uv_action_reg;    // Undervoltage fault action
  logic [15:0] out_good_reg;         // Power good threshold
  logic [15:0] on_delay_reg;         // Turn-on delay time
  logic [15:0] on_ramp_reg;          // Turn-on ramp time
  logic [15:0] off_delay_reg;        // Turn-off delay time
  logic [15:0] off_ramp_reg;         // Turn-off ramp time
  logic [15:0] summary_reg;          // Summary word; low byte is the byte view

  // Pin synchronisers
  logic        en_meta_reg;          // First stage of enable pin
  logic        en_sync_reg;          // Usable enable level
  logic [31:0] strap_meta_reg;       // First stage of strap pins
  logic [31:0] strap_sync_reg;       // Usable strap levels
  logic [1:0]  strap_cnt_reg;        // Cycles since reset release
  logic        strap_done_reg;       // Strap defaults loaded

  // Monitors and sequencer
  logic        uv_fault_reg;         // Latched input undervoltage fault
  logic        pgood_reg;            // Power good level
  logic        cml_reg;              // Sticky bad-command flag
  logic        shut_reg;             // Latched shutdown from other faults
  smsr_state_t state_reg;            // Sequencer state
  smsr_state_t state_next;           // Next sequencer state
  logic [31:0] div_reg;              // Millisecond divider
  logic [15:0] ms_reg;               // Milliseconds in current state
  logic        ms_tick;              // One-cycle millisecond enable
  logic [15:0] wait_ms;              // Time due in current state
  logic        elapsed;              // Current state time is up

  // Comparisons
  logic vin_ov_warn;                 // Input above overvoltage warning
  logic vin_uv_warn;                 // Input below undervoltage warning
  logic vin_below_fault;             // Input below undervoltage fault
  logic vin_above_warn;              // Input back above warning level
  logic vout_uv;                     // Output below undervoltage limit
  logic powered;                     // Output stage delivering power
  logic hard_fault;                  // Fault that shuts the unit down
  logic cmd_bad;                     // Write to read-only or unknown code
  logic [2:0]  retry_mode;           // Retry setting field
  logic [15:0] retry_ms;             // Retry spacing in milliseconds
  logic [15:0] summary_next;         // Live summary value
  logic [15:0] l11_uv_warn_def;      // Strap-derived warning default
  logic [19:0] pg_prod;              // Strap output setting times nine tenths

  // Threshold comparisons
  assign vin_ov_warn     = l11_fix(VIN_MEAS) > l11_fix(vin_ov_warn_reg);
  assign vin_uv_warn     = l11_fix(VIN_MEAS) < l11_fix(vin_uv_warn_reg);
  assign vin_below_fault = l11_fix(VIN_MEAS) < l11_fix(vin_uv_fault_reg);
  assign vin_above_warn  = l11_fix(VIN_MEAS) > l11_fix(vin_uv_warn_reg);
  assign vout_uv         = VOUT_MEAS < VOUT_UV_LIMIT;
  assign hard_fault      = FAULTS.out_ov_fault | FAULTS.out_oc_fault | FAULTS.temp_fault;
  assign retry_mode      = vin_uv_action_reg[RETRY_MODE_HI:RETRY_MODE_LO];
  // Spacing in whole milliseconds
  assign retry_ms = 16'(({13'h0, vin_uv_action_reg[RETRY_DLY_HI:RETRY_DLY_LO]} + 16'h0001)
                        * 16'(RETRY_STEP_MS));
  assign powered  = (state_reg == SMSR_RISE) || (state_reg == SMSR_ON) ||
                    (state_reg == SMSR_OFF_DELAY) || (state_reg == SMSR_FALL);

  // Strap scaling: warning = 1.1 x fault, good = 0.9 x output setting
  always_comb begin
    logic [14:0] man;
    logic [4:0]  ex;
    ex  = strap_sync_reg[L11_EXP_HI:L11_EXP_LO];
    man = 15'(({4'h0, strap_sync_reg[L11_MAN_HI:0]} * UV_WARN_NUM) / 15'(SCALE_DEN));
    if (man > L11_MAN_MAX) begin
      man = man >> 1;
      ex  = ex + 5'h01;
    end
    l11_uv_warn_def = {ex, man[10:0]};
    pg_prod         = 20'(({4'h0, strap_sync_reg[31:16]} * PG_NUM) / SCALE_DEN);
  end

  // Pin synchronisers for enable and straps
  always_ff @(posedge CLK) begin
    en_meta_reg    <= ENABLE_PIN;
    en_sync_reg    <= en_meta_reg;
    strap_meta_reg <= {STRAP_VOUT, STRAP_UV_FAULT};
    strap_sync_reg <= strap_meta_reg;
  end

  // Strap capture a few cycles after reset release
  always_ff @(posedge CLK) begin
    if (RESET) begin
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_cnt_reg  <= strap_cnt_reg + 2'h1;
      strap_done_reg <= (strap_cnt_reg == STRAP_LOAD_CYC);
    end
  end

  // Writes reach only read-write codes
  always_comb begin
    unique case (CMD_CODE)
      CMD_VIN_OV_WARN, CMD_VIN_UV_WARN, CMD_VIN_UV_FAULT, CMD_VIN_UV_ACTION,
      CMD_OUT_GOOD, CMD_ON_DELAY, CMD_ON_RAMP, CMD_OFF_DELAY, CMD_OFF_RAMP: cmd_bad = 1'b0;
      default: cmd_bad = 1'b1; // Summaries are read-only
    endcase
  end

  // Register writes and strap defaults
  always_ff @(posedge CLK) begin
    if (RESET) begin
      vin_ov_warn_reg   <= RST_VIN_OV_WARN;
      vin_uv_warn_reg   <= 16'h0000;
      vin_uv_fault_reg  <= 16'h0000;
      vin_uv_action_reg <= RST_VIN_UV_ACTION;
      out_good_reg      <= 16'h0000;
      on_delay_reg      <= RST_SEQ_TIME;
      on_ramp_reg       <= RST_SEQ_TIME;
      off_delay_reg     <= RST_SEQ_TIME;
      off_ramp_reg      <= RST_SEQ_TIME;
    end else if (!strap_done_reg && strap_cnt_reg == STRAP_LOAD_CYC) begin
      vin_uv_fault_reg  <= strap_sync_reg[15:0];
      vin_uv_warn_reg   <= l11_uv_warn_def;
      out_good_reg      <= pg_prod[15:0];
    end else if (CMD_WR) begin
      unique case (CMD_CODE)
        CMD_VIN_OV_WARN:   vin_ov_warn_reg   <= CMD_WDATA;
        CMD_VIN_UV_WARN:   vin_uv_warn_reg   <= CMD_WDATA;
        CMD_VIN_UV_FAULT:  vin_uv_fault_reg  <= CMD_WDATA;
        CMD_VIN_UV_ACTION: vin_uv_action_reg <= CMD_WDATA[7:0];
        CMD_OUT_GOOD:      out_good_reg      <= CMD_WDATA;
        CMD_ON_DELAY:      on_delay_reg      <= CMD_WDATA;
        CMD_ON_RAMP:       on_ramp_reg       <= CMD_WDATA;
        CMD_OFF_DELAY:     off_delay_reg     <= CMD_WDATA;
        CMD_OFF_RAMP:      off_ramp_reg      <= CMD_WDATA;
        default: ;
      endcase
    end
  end

  // Read answers, one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RD_DATA  <= 16'h0000;
      RD_VALID <= 1'b0;
      CMD_ERR  <= 1'b0;
    end else begin
      RD_VALID <= CMD_RD;
      CMD_ERR  <= CMD_WR & cmd_bad;
      if (CMD_RD) begin
        unique case (CMD_CODE)
          CMD_VIN_OV_WARN:   RD_DATA <= vin_ov_warn_reg;
          CMD_VIN_UV_WARN:   RD_DATA <= vin_uv_warn_reg;
          CMD_VIN_UV_FAULT:  RD_DATA <= vin_uv_fault_reg;
          CMD_VIN_UV_ACTION: RD_DATA <= {8'h00, vin_uv_action_reg};
          CMD_OUT_GOOD:      RD_DATA <= out_good_reg;
          CMD_ON_DELAY:      RD_DATA <= on_delay_reg;
          CMD_ON_RAMP:       RD_DATA <= on_ramp_reg;
          CMD_OFF_DELAY:     RD_DATA <= off_delay_reg;
          CMD_OFF_RAMP:      RD_DATA <= off_ramp_reg;
          CMD_SUM_BYTE:      RD_DATA <= {8'h00, summary_reg[7:0]};
          CMD_SUM_WORD:      RD_DATA <= summary_reg;
          default:           RD_DATA <= 16'h0000;
        endcase
      end
    end
  end

  // Undervoltage fault with hysteresis and sticky bad-command flag
  always_ff @(posedge CLK) begin
    if (RESET) begin
      uv_fault_reg <= 1'b0;
      cml_reg      <= 1'b0;
    end else begin
      if (vin_below_fault) begin
        uv_fault_reg <= 1'b1;
      end else if (vin_above_warn) begin
        uv_fault_reg <= 1'b0;
      end
      // Set wins over clear
      cml_reg <= (CMD_WR & cmd_bad) | (cml_reg & ~CLEAR_FAULTS);
    end
  end

  // Power good hysteresis
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pgood_reg <= 1'b0;
    end else if (vout_uv) begin
      // Negation wins, so good never stands below the fault limit
      pgood_reg <= 1'b0;
    end else if (VOUT_MEAS > out_good_reg) begin
      pgood_reg <= 1'b1;
    end
  end

  // Shutdown latch from other faults, released by disable
  always_ff @(posedge CLK) begin
    if (RESET) begin
      shut_reg <= 1'b0;
    end else if (hard_fault) begin
      shut_reg <= 1'b1;
    end else if (!en_sync_reg) begin
      shut_reg <= 1'b0;
    end
  end

  // Time due in the current state
  always_comb begin
    unique case (state_reg)
      SMSR_ON_DELAY:  wait_ms = l11_ms(on_delay_reg);
      SMSR_RISE:      wait_ms = l11_ms(on_ramp_reg);
      SMSR_OFF_DELAY: wait_ms = l11_ms(off_delay_reg);
      SMSR_FALL:      wait_ms = l11_ms(off_ramp_reg);
      SMSR_RETRY:     wait_ms = retry_ms;
      default:        wait_ms = 16'h0000;
    endcase
  end
  assign elapsed = ms_reg >= wait_ms;
  assign ms_tick = div_reg == 32'(CYC_MS - 1);

  // Millisecond divider and state timer, restarted on every state change
  always_ff @(posedge CLK) begin
    if (RESET || state_next != state_reg) begin
      div_reg <= 32'h0000_0000;
      ms_reg  <= 16'h0000;
    end else if (ms_tick) begin
      div_reg <= 32'h0000_0000;
      ms_reg  <= (ms_reg == 16'hFFFF) ? ms_reg : ms_reg + 16'h0001;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
    end
  end

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SMSR_OFF: begin
        if (en_sync_reg && !uv_fault_reg && !shut_reg) begin
          state_next = SMSR_ON_DELAY;
        end
      end
      SMSR_ON_DELAY, SMSR_RISE, SMSR_ON: begin
        if (shut_reg || hard_fault) begin
          state_next = SMSR_OFF;
        end else if (uv_fault_reg && state_reg != SMSR_ON_DELAY) begin
          // Delay passes without an undervoltage fault check, so a retry really restarts
          // Retry only in continuous mode; other codes stay off
          state_next = (retry_mode == RETRY_CONT) ? SMSR_RETRY : SMSR_OFF;
        end else if (!en_sync_reg) begin
          state_next = (state_reg == SMSR_ON_DELAY) ? SMSR_OFF : SMSR_OFF_DELAY;
        end else if (state_reg != SMSR_ON && elapsed) begin
          state_next = (state_reg == SMSR_ON_DELAY) ? SMSR_RISE : SMSR_ON;
        end
      end
      SMSR_OFF_DELAY: begin
        if (hard_fault) begin
          state_next = SMSR_OFF;
        end else if (elapsed) begin
          state_next = SMSR_FALL;
        end
      end
      SMSR_FALL: begin
        if (hard_fault || elapsed) begin
          state_next = SMSR_OFF;
        end
      end
      SMSR_RETRY: begin
        if (!en_sync_reg || shut_reg || hard_fault) begin
          state_next = SMSR_OFF;
        end else if (elapsed) begin
          state_next = SMSR_ON_DELAY;
        end
      end
      default: state_next = SMSR_OFF;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg <= SMSR_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Live summary from detector flags
  always_comb begin
    summary_next          = 16'h0000;
    summary_next[SB_BUSY] = FAULTS.busy_fault;
    summary_next[SB_OFF]  = ~powered;
    summary_next[SB_VOOV] = FAULTS.out_ov_fault;
    summary_next[SB_IOOC] = FAULTS.out_oc_fault;
    summary_next[SB_VIUV] = uv_fault_reg;
    summary_next[SB_TEMP] = FAULTS.temp_alert | FAULTS.temp_fault;
    summary_next[SB_CML]  = FAULTS.comm_fault | cml_reg;
    summary_next[SB_NOTA] = vin_ov_warn | vin_uv_warn | FAULTS.vout_warn |
                            FAULTS.iout_warn | FAULTS.mfr_alert |
                            FAULTS.fan_alert | FAULTS.other_alert |
                            FAULTS.unknown_alert;
    summary_next[SW_VOUT] = FAULTS.out_ov_fault | FAULTS.vout_warn | vout_uv;
    summary_next[SW_IOUT] = FAULTS.out_oc_fault | FAULTS.iout_warn;
    summary_next[SW_INP]  = vin_ov_warn | vin_uv_warn | uv_fault_reg;
    summary_next[SW_MFR]  = FAULTS.mfr_alert;
    summary_next[SW_PGN]  = ~pgood_reg;
    summary_next[SW_FANS] = FAULTS.fan_alert;
    summary_next[SW_OTH]  = FAULTS.other_alert;
    summary_next[SW_UNK]  = FAULTS.unknown_alert;
  end

  // Summary register, refreshed every clock
  always_ff @(posedge CLK) begin
    if (RESET) begin
      summary_reg <= RST_SUMMARY;
    end else begin
      summary_reg <= summary_next;
    end
  end

  // Outputs to output stage and alert pin
  always_ff @(posedge CLK) begin
    if (RESET) begin
      OUTPUT_ON  <= 1'b0;
      RAMP_UP    <= 1'b0;
      RAMP_DOWN  <= 1'b0;
      POWER_GOOD <= 1'b0;
      ALERT_OE   <= 1'b0;
    end else begin
      OUTPUT_ON  <= (state_next == SMSR_RISE) || (state_next == SMSR_ON) ||
                    (state_next == SMSR_OFF_DELAY) || (state_next == SMSR_FALL);
      RAMP_UP    <= state_next == SMSR_RISE;
      RAMP_DOWN  <= state_next == SMSR_FALL;
      POWER_GOOD <= pgood_reg;
      // Pull alert low on any event other than plain off or not-good
      ALERT_OE   <= |(summary_next & ~(16'h0001 << SW_PGN) & ~(16'h0001 << SB_OFF));
    end
  end
  assign ALERT_O = 1'b0;

endmodule
`default_nettype wire

// ---- sim/smsr_properties.sv ----
// Port checker of the status register bank
`timescale 1ns/1ps
`default_nettype none
module smsr_properties
  import smsr_pkg::*;
(
  // Clock, reset and command port
  input wire logic                   CLK, RESET, CMD_WR, CMD_RD, RD_VALID, CMD_ERR,
  input wire logic [7:0]             CMD_CODE,
  input wire logic [15:0]            RD_DATA, VOUT_MEAS, VOUT_UV_LIMIT,
  // Detector flags and output stage
  input wire smsr_pkg::smsr_faults_t FAULTS,
  input wire logic                   OUTPUT_ON, RAMP_UP, RAMP_DOWN, POWER_GOOD, ALERT_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_ro_refuse: assert property (CMD_WR && CMD_CODE == CMD_SUM_WORD |=> CMD_ERR)
    else $error("write to summary not refused");
  a_byte_low: assert property (CMD_RD && CMD_CODE == CMD_SUM_BYTE |=> RD_DATA[15:8] == 8'h00)
    else $error("summary byte high half set");
  a_off_bit: assert property (CMD_RD && CMD_CODE == CMD_SUM_WORD && !OUTPUT_ON
    && $past(OUTPUT_ON) == 1'b0 && $past(RESET, 2) == 1'b0 |=> RD_DATA[SB_OFF])
    else $error("off bit clear while unpowered");
  a_pgn_bit: assert property (CMD_RD && CMD_CODE == CMD_SUM_WORD && !POWER_GOOD
    && $past(POWER_GOOD) == 1'b0 && $past(RESET, 2) == 1'b0 |=> RD_DATA[SW_PGN])
    else $error("power good bit clear while negated");
  a_ramp_excl: assert property (RAMP_UP |-> OUTPUT_ON && !RAMP_DOWN)
    else $error("ramp up outside powered state");
  a_pg_drop: assert property (VOUT_MEAS < VOUT_UV_LIMIT |-> ##[1:3] !POWER_GOOD)
    else $error("power good kept below limit");
  a_hard_off: assert property (FAULTS.out_ov_fault |-> ##[1:3] !OUTPUT_ON)
    else $error("output kept on after hard fault");
  a_alert_temp: assert property (FAULTS.temp_alert [*4] |-> ALERT_OE)
    else $error("no alert on temperature flag");
endmodule
bind smsr_regs smsr_properties i_props (.CLK(CLK), .RESET(RESET), .CMD_WR(CMD_WR),
  .CMD_RD(CMD_RD), .RD_VALID(RD_VALID), .CMD_ERR(CMD_ERR), .CMD_CODE(CMD_CODE),
  .RD_DATA(RD_DATA), .VOUT_MEAS(VOUT_MEAS), .VOUT_UV_LIMIT(VOUT_UV_LIMIT), .FAULTS(FAULTS),
  .OUTPUT_ON(OUTPUT_ON), .RAMP_UP(RAMP_UP), .RAMP_DOWN(RAMP_DOWN), .POWER_GOOD(POWER_GOOD),
  .ALERT_OE(ALERT_OE));
`default_nettype wire

// ---- sim/smsr_host.sv ----
// Host controller model on the command port
`timescale 1ns/1ps
`default_nettype none
module smsr_host (
  // Clock and answer
  input wire logic         CLK, RD_VALID,
  input wire logic [15:0]  RD_DATA,
  // Requests
  output logic [7:0]       CMD_CODE,
  output logic             CMD_WR, CMD_RD, CLEAR_FAULTS,
  output logic [15:0]      CMD_WDATA
);
  initial {CMD_CODE, CMD_WR, CMD_RD, CLEAR_FAULTS, CMD_WDATA} = '0;
  // One-cycle write strobe; released lines show the inverse
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    @(negedge CLK) {CMD_CODE, CMD_WDATA, CMD_WR} = {c, v, 1'b1};
    @(negedge CLK) {CMD_CODE, CMD_WDATA, CMD_WR} = {~c, ~v, 1'b0};
  endtask
  // Read answer is taken the cycle after the strobe
  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    @(negedge CLK) {CMD_CODE, CMD_RD} = {c, 1'b1};
    @(negedge CLK) {CMD_CODE, CMD_RD} = {~c, 1'b0};
    v = RD_VALID ? RD_DATA : 16'hxxxx;
  endtask
  // Clear pulse for sticky flags
  task automatic clr();
    @(negedge CLK) CLEAR_FAULTS = 1'b1;
    @(negedge CLK) CLEAR_FAULTS = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench of the status register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import smsr_pkg::*;
  logic CLK = 0, RESET = 1, EN = 0, WR, RD, RV, ERR, CLR, ON, RU, RDN, PG, AO, AOE;
  logic [15:0] VIN = 16'hD300, VOUT = 16'h0000, VUV = 16'h0000, RDD, WD, d;
  logic [7:0] CODE;
  smsr_faults_t F = '0;
  int n_mismatch = 0, num_checks = 0, n;
  wire [2:0] mon = {RDN, RU, ON};
  logic [15:0] fx [12] = '{16'h8860, 16'h4850, 16'h8841, 16'h4841, 16'h0844, 16'h0844,
    16'h0842, 16'h08C0, 16'h1841, 16'h0C41, 16'h0A41, 16'h0941};
  always #4 CLK = ~CLK;
  smsr_regs #(.CYC_MS(10)) i_smsr_regs (.CLK(CLK), .RESET(RESET), .CMD_CODE(CODE),
    .CMD_WR(WR), .CMD_WDATA(WD), .CMD_RD(RD), .RD_DATA(RDD), .RD_VALID(RV), .CMD_ERR(ERR),
    .CLEAR_FAULTS(CLR), .VIN_MEAS(VIN), .VOUT_MEAS(VOUT), .VOUT_UV_LIMIT(VUV), .FAULTS(F),
    .ENABLE_PIN(EN), .STRAP_UV_FAULT(16'hD200), .STRAP_VOUT(16'h1000), .OUTPUT_ON(ON),
    .RAMP_UP(RU), .RAMP_DOWN(RDN), .POWER_GOOD(PG), .ALERT_O(AO), .ALERT_OE(AOE));
  smsr_host i_smsr_host (.CLK(CLK), .RD_VALID(RV), .RD_DATA(RDD), .CMD_CODE(CODE),
    .CMD_WR(WR), .CMD_RD(RD), .CLEAR_FAULTS(CLR), .CMD_WDATA(WD));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [7:0] c, input logic [15:0] e);
    i_smsr_host.rd(c, d);
    chk(d, e);
  endtask
  task automatic wt(input int k);
    repeat (k) @(negedge CLK);
  endtask
  // Cycles until a monitored output reaches a level
  task automatic span(input int b, input logic v);
    for (n = 0; mon[b] !== v && n < 2000; n++) @(negedge CLK);
  endtask
  task automatic t_defaults();
    for (int i = 0; i < 4; i++) rc(CMD_ON_DELAY + 8'(i / 2 * 2 + i), 16'hCA80);
    rc(CMD_VIN_OV_WARN, 16'hD34D);
    rc(CMD_VIN_UV_ACTION, 16'h0080);
    rc(CMD_VIN_UV_WARN, 16'hD233);
    rc(CMD_OUT_GOOD, 16'h0E66);
    rc(CMD_SUM_WORD, 16'h0840);
  endtask
  task automatic t_refuse();
    i_smsr_host.wr(CMD_SUM_WORD, 16'hFFFF);
    rc(CMD_SUM_WORD, 16'h0842);
    rc(CMD_SUM_BYTE, 16'h0042);
    i_smsr_host.clr();
    i_smsr_host.wr(8'h70, 16'h1234);
    rc(8'h70, 16'h0000);
    i_smsr_host.clr();
    rc(CMD_SUM_WORD, 16'h0840);
  endtask
  task automatic t_faults();
    foreach (fx[i]) begin
      @(negedge CLK) F = smsr_faults_t'(12'h800 >> i);
      wt(5);
      rc(CMD_SUM_WORD, fx[i]);
      F = '0;
    end
  endtask
  task automatic t_vin();
    VIN = 16'hD360;
    wt(4);
    rc(CMD_SUM_WORD, 16'h2841);
    VIN = 16'hD220;
    wt(4);
    rc(CMD_SUM_WORD, 16'h2841);
    VIN = 16'hD100;
    wt(4);
    VIN = 16'hD220;
    wt(4);
    rc(CMD_SUM_WORD, 16'h2849);
    VIN = 16'hD300;
    wt(4);
    rc(CMD_SUM_WORD, 16'h0840);
  endtask
  task automatic t_seq();
    for (int c = 0; c < 4; c++) i_smsr_host.wr(CMD_ON_DELAY + 8'(c / 2 * 2 + c), 16'h0001);
    EN = 1;
    span(1, 1);
    chk(16'(n > 9 && n < 15), 16'h0001);
    span(1, 0);
    chk(16'(n), 16'd11);
    VOUT = 16'h1000;
    wt(4);
    rc(CMD_SUM_WORD, 16'h0000);
    VUV = 16'h1100;
    wt(4);
    chk(16'(PG), 16'h0000);
    VUV = 16'h0000;
    EN = 0;
    span(2, 1);
    chk(16'(n > 9 && n < 15), 16'h0001);
    span(2, 0);
    chk(16'(n), 16'd11);
  endtask
  task automatic t_retry();
    i_smsr_host.wr(CMD_VIN_UV_ACTION, 16'h00B9);
    EN = 1;
    span(1, 1);
    span(1, 0);
    VIN = 16'hD100;
    span(0, 0);
    span(1, 1);
    chk(16'(n > 699 && n < 721), 16'h0001);
    i_smsr_host.wr(CMD_VIN_UV_ACTION, 16'h0080);
    span(0, 1);
    span(0, 0);
    span(0, 1);
    chk(16'(n), 16'd2000);
    chk(16'(ON), 16'h0000);
    VIN = 16'hD300;
    EN = 0;
    wt(100);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    complete_run();
  end
  initial begin
    wt(6);
    RESET = 0;
    wt(10);
    t_defaults();
    t_refuse();
    t_faults();
    t_vin();
    t_seq();
    t_retry();
    complete_run();
  end
endmodule
`default_nettype wire
